/* common/adcirq_consts.svh */
// register indices, field positions, masks and reset values of the
// converter status/mode/result register bank
// assumes: included by bare name, before any use of the macros
`ifndef ADCIRQ_CONSTS_SVH
`define ADCIRQ_CONSTS_SVH

// register indices; byte address is four times the index
`define ADCIRQ_IDX_MANUAL 8'h40
`define ADCIRQ_IDX_STATUS 8'h42
`define ADCIRQ_IDX_MODE 8'h44
`define ADCIRQ_IDX_RESULT1 8'h46
`define ADCIRQ_IDX_RESULT2 8'h48
`define ADCIRQ_IDX_MASK 8'h4A

// interrupt status bit positions
`define ADCIRQ_BIT_FIFO 15
`define ADCIRQ_BIT_SEQUENCER_TWO_DONE 14
`define ADCIRQ_BIT_SEQUENCER_ONE_DONE 13
`define ADCIRQ_BIT_CMP 12

// mode and manual control fields
`define ADCIRQ_BIT_OVERRIDE 0
`define ADCIRQ_BIT_PWR1 8
`define ADCIRQ_BIT_PWR2 9
`define ADCIRQ_CH1_LSB 0
`define ADCIRQ_CH2_LSB 4

// writable bits of each register, and the value bits of the read-only results
`define ADCIRQ_STATUS_WMASK 16'hF000
`define ADCIRQ_MODE_WMASK 16'h0001
`define ADCIRQ_MANUAL_WMASK 16'h03FF
`define ADCIRQ_RESULT_MASK 16'h0FFF

// reset values
`define ADCIRQ_RST_REG 16'h0000
`define ADCIRQ_RST_SAMPLE 12'h000

// bus answers
`define ADCIRQ_RESP_OKAY 2'h0
`define ADCIRQ_RESP_SLVERR 2'h2

`endif

/* common/adcirq_pkg.sv */
// types shared by the converter register bank files
// assumes: compiled before every design file
package adcirq_pkg;
  typedef logic [15:0] adcirq_reg_t;
  typedef logic [11:0] adcirq_sample_t;
  typedef logic [3:0] adcirq_chan_t;
  typedef logic [1:0] adcirq_resp_t;
endpackage

/* core/adcirq_regs.sv */
// converter interrupt status, mode, manual control and result registers
// assumes: AXI4-Lite master on aclk; event inputs come from aclk logic
// assumes: sample strobes last one cycle and qualify the value only then
// unmapped word indices answer SLVERR; upper 16 data bits are ignored
//
// What this block does
// RULE1 - status bits latch events, raise irq if enabled, clear on write 1
// RULE2 - bit 15 sets when sample fifo fill reaches its threshold
// RULE3 - bit 14 sets when the second sequencer completes a pass
// RULE4 - bit 13 sets when the first sequencer completes a pass
// RULE5 - bit 12 sets when any comparator fires; channel read elsewhere
// RULE6 - mode bit 0 set selects manual override, clear selects automated
// RULE7 - results hold 12-bit unsigned value in bits 11:0, upper bits zero
// RULE8 - results are read-only and capture samples during manual override
// RULE9 - status bits 11:0 reserved read-only; all status bits reset to zero
// RULE10 - manual power and channel fields act only while override is set
// RULE11 - manual bits 8,9 power converters; bits 3:0, 7:4 pick channels
// RULE12 - writes to reserved or read-only bits ignored; write 0 keeps status
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "adcirq_consts.svh"

module adcirq_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // events from fifo, sequencers and comparators
  input wire logic fifo_at_threshold,
  input wire logic sequencer_one_done,
  input wire logic sequencer_two_done,
  input wire logic comparator_fired,
  // converter samples
  input wire logic first_sample_strobe,
  input wire adcirq_pkg::adcirq_sample_t first_sample_value,
  input wire logic second_sample_strobe,
  input wire adcirq_pkg::adcirq_sample_t second_sample_value,
  // converter control
  output logic manual_override,
  output logic first_converter_power,
  output logic second_converter_power,
  output adcirq_pkg::adcirq_chan_t first_channel_select,
  output adcirq_pkg::adcirq_chan_t second_channel_select,
  // interrupt
  output logic irq
);
  // register state
  adcirq_pkg::adcirq_reg_t status_q, status_d;
  adcirq_pkg::adcirq_reg_t mask_q, mask_d;
  adcirq_pkg::adcirq_reg_t mode_q, mode_d;
  adcirq_pkg::adcirq_reg_t manual_q, manual_d;
  adcirq_pkg::adcirq_sample_t result1_q, result2_q;

  // write path holding state
  logic [7:0] waddr_q;
  logic waddr_bad_q;
  logic aw_held_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic w_held_q;

  // handshakes
  wire logic aw_hs;
  wire logic w_hs;
  wire logic b_hs;
  wire logic ar_hs;
  wire logic r_hs;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign b_hs = s_axi_bvalid && s_axi_bready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign r_hs = s_axi_rvalid && s_axi_rready;

  // write commit happens once both halves are held and no answer pends
  wire logic wr_go;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  // write decode
  wire logic wr_status;
  wire logic wr_mask;
  wire logic wr_mode;
  wire logic wr_manual;
  wire logic wr_known;
  assign wr_status = wr_go && !waddr_bad_q &&
                     waddr_q == `ADCIRQ_IDX_STATUS;
  assign wr_mask = wr_go && !waddr_bad_q && waddr_q == `ADCIRQ_IDX_MASK;
  assign wr_mode = wr_go && !waddr_bad_q && waddr_q == `ADCIRQ_IDX_MODE;
  assign wr_manual = wr_go && !waddr_bad_q &&
                     waddr_q == `ADCIRQ_IDX_MANUAL;
  // result registers are mapped but read-only: writes answer okay
  assign wr_known = !waddr_bad_q &&
                    (waddr_q == `ADCIRQ_IDX_STATUS ||
                     waddr_q == `ADCIRQ_IDX_MASK ||
                     waddr_q == `ADCIRQ_IDX_MODE ||
                     waddr_q == `ADCIRQ_IDX_MANUAL ||
                     waddr_q == `ADCIRQ_IDX_RESULT1 ||
                     waddr_q == `ADCIRQ_IDX_RESULT2);

  // byte lanes 0 and 1 only; upper lanes have no storage
  wire adcirq_pkg::adcirq_reg_t lane_mask;
  assign lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // events gathered into status layout
  wire adcirq_pkg::adcirq_reg_t event_set;
  assign event_set = {fifo_at_threshold, // [RULE2]
                      sequencer_two_done, // [RULE3]
                      sequencer_one_done, // [RULE4]
                      comparator_fired, // [RULE5]
                      12'h000}; // [RULE9]

  // a one written to a status bit clears it; a zero leaves it alone
  wire adcirq_pkg::adcirq_reg_t status_clr;
  assign status_clr = wr_status ?
                      (wdata_q & lane_mask & `ADCIRQ_STATUS_WMASK) :
                      `ADCIRQ_RST_REG; // [RULE12]

  // set beats clear so an event landing on the clearing write survives
  assign status_d = ((status_q & ~status_clr) | event_set) &
                    `ADCIRQ_STATUS_WMASK; // [RULE1] [RULE9]

  wire adcirq_pkg::adcirq_reg_t mask_wm;
  wire adcirq_pkg::adcirq_reg_t mode_wm;
  wire adcirq_pkg::adcirq_reg_t manual_wm;
  assign mask_wm = lane_mask & `ADCIRQ_STATUS_WMASK;
  assign mode_wm = lane_mask & `ADCIRQ_MODE_WMASK;
  assign manual_wm = lane_mask & `ADCIRQ_MANUAL_WMASK;

  assign mask_d = wr_mask ?
                  ((mask_q & ~mask_wm) | (wdata_q & mask_wm)) :
                  mask_q; // [RULE12]
  assign mode_d = wr_mode ?
                  ((mode_q & ~mode_wm) | (wdata_q & mode_wm)) :
                  mode_q; // [RULE6] [RULE12]
  assign manual_d = wr_manual ?
                    ((manual_q & ~manual_wm) | (wdata_q & manual_wm)) :
                    manual_q; // [RULE11] [RULE12]

  // mode and manual fields as seen by the converters
  wire logic override_on;
  wire logic pwr1_d;
  wire logic pwr2_d;
  wire adcirq_pkg::adcirq_chan_t ch1_d;
  wire adcirq_pkg::adcirq_chan_t ch2_d;
  assign override_on = mode_q[`ADCIRQ_BIT_OVERRIDE]; // [RULE6]
  // in automated mode the sequencers own the converters, so hold these off
  assign pwr1_d = override_on && manual_q[`ADCIRQ_BIT_PWR1]; // [RULE10]
  assign pwr2_d = override_on && manual_q[`ADCIRQ_BIT_PWR2]; // [RULE10]
  assign ch1_d = override_on ?
                 manual_q[`ADCIRQ_CH1_LSB +: 4] : 4'h0; // [RULE10] [RULE11]
  assign ch2_d = override_on ?
                 manual_q[`ADCIRQ_CH2_LSB +: 4] : 4'h0; // [RULE10] [RULE11]

  // result capture, one holder per converter
  adcirq_result u_result1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .capture_en(override_on), // [RULE8]
    .sample_strobe(first_sample_strobe),
    .sample_value(first_sample_value),
    .result_q(result1_q)
  );

  adcirq_result u_result2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .capture_en(override_on), // [RULE8]
    .sample_strobe(second_sample_strobe),
    .sample_value(second_sample_value),
    .result_q(result2_q)
  );

  // read decode
  wire logic [7:0] ridx;
  wire logic rd_bad;
  assign ridx = s_axi_araddr[9:2];
  assign rd_bad = s_axi_araddr[11:10] != 2'h0;

  wire logic rd_status;
  wire logic rd_mask;
  wire logic rd_mode;
  wire logic rd_manual;
  wire logic rd_res1;
  wire logic rd_res2;
  assign rd_status = !rd_bad && ridx == `ADCIRQ_IDX_STATUS;
  assign rd_mask = !rd_bad && ridx == `ADCIRQ_IDX_MASK;
  assign rd_mode = !rd_bad && ridx == `ADCIRQ_IDX_MODE;
  assign rd_manual = !rd_bad && ridx == `ADCIRQ_IDX_MANUAL;
  assign rd_res1 = !rd_bad && ridx == `ADCIRQ_IDX_RESULT1;
  assign rd_res2 = !rd_bad && ridx == `ADCIRQ_IDX_RESULT2;

  wire logic rd_known;
  assign rd_known = rd_status || rd_mask || rd_mode || rd_manual ||
                    rd_res1 || rd_res2;

  // results zero-extend; the 4 bits above the sample read as zero
  wire adcirq_pkg::adcirq_reg_t rd_word;
  assign rd_word = rd_status ? status_q :
                   rd_mask ? mask_q :
                   rd_mode ? mode_q :
                   rd_manual ? manual_q :
                   rd_res1 ? {4'h0, result1_q} : // [RULE7]
                   rd_res2 ? {4'h0, result2_q} : // [RULE7]
                   `ADCIRQ_RST_REG;

  // upper half of the answer word carries no storage
  wire logic [31:0] rdata_d;
  assign rdata_d = {16'h0000, rd_word};

  // write address capture; word index from bits 9:2, upper bits checked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_q <= 8'h00;
      waddr_bad_q <= 1'b0;
      aw_held_q <= 1'b0;
    end else if (aw_hs) begin
      waddr_q <= s_axi_awaddr[9:2];
      waddr_bad_q <= s_axi_awaddr[11:10] != 2'h0;
      aw_held_q <= 1'b1;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_q <= `ADCIRQ_RST_REG;
      wstrb_q <= 2'h0;
      w_held_q <= 1'b0;
    end else if (w_hs) begin
      wdata_q <= s_axi_wdata[15:0];
      wstrb_q <= s_axi_wstrb[1:0];
      w_held_q <= 1'b1;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // write channel readies: closed from the take until the answer is taken;
  // an unanswered response keeps them shut even while bready is held low
  wire logic awready_d;
  wire logic wready_d;
  assign awready_d = (!(aw_held_q || aw_hs) && !s_axi_bvalid) || b_hs;
  assign wready_d = (!(w_held_q || w_hs) && !s_axi_bvalid) || b_hs;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
    end
  end

  // write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCIRQ_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `ADCIRQ_RESP_OKAY : `ADCIRQ_RESP_SLVERR;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ADCIRQ_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rd_known ? `ADCIRQ_RESP_OKAY : `ADCIRQ_RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= `ADCIRQ_RST_REG; // [RULE9]
      mask_q <= `ADCIRQ_RST_REG;
      mode_q <= `ADCIRQ_RST_REG; // [RULE6]
      manual_q <= `ADCIRQ_RST_REG;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      mode_q <= mode_d;
      manual_q <= manual_d;
    end
  end

  // registered outputs toward the converters and the interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      manual_override <= 1'b0;
      first_converter_power <= 1'b0;
      second_converter_power <= 1'b0;
      first_channel_select <= 4'h0;
      second_channel_select <= 4'h0;
      irq <= 1'b0;
    end else begin
      manual_override <= override_on;
      first_converter_power <= pwr1_d;
      second_converter_power <= pwr2_d;
      first_channel_select <= ch1_d;
      second_channel_select <= ch2_d;
      // irq lags status by a cycle so it leaves a flop, not a gate
      irq <= |(status_q & mask_q); // [RULE1]
    end
  end
endmodule

/* core/adcirq_result.sv */
// one converter result holder: captures a sample strobe in manual mode
// assumes: strobe and value come from logic on aclk, no crossing needed
`timescale 1ns/1ns
`include "adcirq_consts.svh"

module adcirq_result (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // capture control
  input wire logic capture_en,
  input wire logic sample_strobe,
  input wire adcirq_pkg::adcirq_sample_t sample_value,
  // held result
  output adcirq_pkg::adcirq_sample_t result_q
);
  adcirq_pkg::adcirq_sample_t result_d;
  wire logic take;

  // automated conversions go elsewhere, so only manual samples land here
  assign take = capture_en && sample_strobe;
  assign result_d = take ? sample_value : result_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= `ADCIRQ_RST_SAMPLE;
    end else begin
      result_q <= result_d;
    end
  end
endmodule

/* testbench/adcirq_regs_sva.sv */
// checker of bus answers, control gating and reset state of the bank
// assumes: bound to adcirq_regs, one clock domain
`timescale 1ns/1ns
module adcirq_regs_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // control and interrupt
  input wire logic manual_override,
  input wire logic first_converter_power,
  input wire logic second_converter_power,
  input wire adcirq_pkg::adcirq_chan_t first_channel_select,
  input wire adcirq_pkg::adcirq_chan_t second_channel_select,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_WR_HELD: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted during answer");
  AST_RD_ANSWER: assert property (
    rd_take |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("read answer late or upper half set");
  AST_RD_HELD: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted during answer");
  AST_PWR_GATED: assert property (
    first_converter_power || second_converter_power |-> manual_override)
    else $error("converter powered in automated mode");
  AST_CH_GATED: assert property (
    !manual_override |-> first_channel_select == 4'h0 &&
    second_channel_select == 4'h0)
    else $error("channel select leaks in automated mode");
  AST_RESET_CLEAR: assert property (
    $rose(aresetn) |-> !irq && !manual_override && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  AST_MODE_BY_WRITE: assert property (
    $changed(manual_override) |->
    $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2))
    else $error("override changed without a write");
endmodule

bind adcirq_regs adcirq_regs_sva adcirq_regs_sva_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .manual_override, .first_converter_power,
  .second_converter_power, .first_channel_select,
  .second_channel_select, .irq);

/* testbench/test_adcirq_regs.sv */
// self-checking bench of the converter status/mode/result bank
// assumes: design compiled with the package and constants header
`timescale 1ns/1ns
`include "adcirq_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_adcirq_regs;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, manual_override, irq;
  logic first_converter_power, second_converter_power;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ev;
  logic [1:0] s_axi_bresp, s_axi_rresp, stb;
  adcirq_pkg::adcirq_sample_t val1, val2;
  adcirq_pkg::adcirq_chan_t first_channel_select, second_channel_select;
  wire logic [10:0] ctl;
  int error_cnt = 0;
  int comparisons = 0;
  assign ctl = {manual_override, first_converter_power,
    second_converter_power, first_channel_select, second_channel_select};
  always #5 aclk = ~aclk;
  adcirq_regs adcirq_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fifo_at_threshold(ev[3]),
    .sequencer_one_done(ev[1]), .sequencer_two_done(ev[2]),
    .comparator_fired(ev[0]), .first_sample_strobe(stb[0]),
    .first_sample_value(val1), .second_sample_strobe(stb[1]),
    .second_sample_value(val2), .manual_override, .first_converter_power,
    .second_converter_power, .first_channel_select,
    .second_channel_select, .irq);
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one bus cycle; gives up after 100 edges
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      error_cnt++;
      $display("ERROR bus answer expected within 100 cycles seen none");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
                    input logic [1:0] r = `ADCIRQ_RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      step(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", r, s_axi_bresp)
  endtask
  task automatic rd(input logic [7:0] idx, input logic [15:0] e,
                    input logic [1:0] r = `ADCIRQ_RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      step(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", {16'h0000, e}, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 4'h0;
  endtask
  task automatic cap(input logic [11:0] a, input logic [11:0] b);
    @(posedge aclk);
    val1 <= a;
    val2 <= b;
    stb <= 2'b11;
    @(posedge aclk);
    stb <= 2'b00;
  endtask
  task automatic t_reset();
    logic [7:0] tab [6];
    tab = '{`ADCIRQ_IDX_MANUAL, `ADCIRQ_IDX_STATUS, `ADCIRQ_IDX_MODE,
      `ADCIRQ_IDX_RESULT1, `ADCIRQ_IDX_RESULT2, `ADCIRQ_IDX_MASK};
    foreach (tab[i]) rd(tab[i], `ADCIRQ_RST_REG);
    rd(8'h41, 16'h0000, `ADCIRQ_RESP_SLVERR);
    wr(8'h41, 16'hFFFF, `ADCIRQ_RESP_SLVERR);
    `CHK("irq", 1'b0, irq)
  endtask
  task automatic t_events();
    logic [15:0] b;
    wr(`ADCIRQ_IDX_MASK, 16'hFFFF);
    rd(`ADCIRQ_IDX_MASK, `ADCIRQ_STATUS_WMASK);
    for (int i = 0; i < 4; i++) begin
      b = 16'h1000 << i;
      pulse(4'h1 << i);
      wr(`ADCIRQ_IDX_STATUS, ~b);
      rd(`ADCIRQ_IDX_STATUS, b);
      `CHK("irq", 1'b1, irq)
      wr(`ADCIRQ_IDX_STATUS, b);
      rd(`ADCIRQ_IDX_STATUS, 16'h0000);
      `CHK("irq", 1'b0, irq)
    end
    wr(`ADCIRQ_IDX_MASK, 16'h0000);
    pulse(4'hF);
    rd(`ADCIRQ_IDX_STATUS, 16'hF000);
    `CHK("irq", 1'b0, irq)
    wr(`ADCIRQ_IDX_STATUS, 16'hF000);
  endtask
  task automatic t_mode();
    wr(`ADCIRQ_IDX_MANUAL, 16'hFFFF);
    rd(`ADCIRQ_IDX_MANUAL, `ADCIRQ_MANUAL_WMASK);
    `CHK("ctrl", 11'h000, ctl)
    wr(`ADCIRQ_IDX_MANUAL, 16'h01A5);
    wr(`ADCIRQ_IDX_MODE, 16'hFFFF);
    rd(`ADCIRQ_IDX_MODE, `ADCIRQ_MODE_WMASK);
    `CHK("ctrl", {3'b110, 4'h5, 4'hA}, ctl)
    wr(`ADCIRQ_IDX_MODE, 16'h0000);
    rd(`ADCIRQ_IDX_MODE, 16'h0000);
    `CHK("ctrl", 11'h000, ctl)
    s_axi_wstrb <= 4'h1;
    wr(`ADCIRQ_IDX_MANUAL, 16'h0000);
    s_axi_wstrb <= 4'hF;
    rd(`ADCIRQ_IDX_MANUAL, 16'h0100);
  endtask
  task automatic t_results();
    cap(12'hABC, 12'h123);
    rd(`ADCIRQ_IDX_RESULT1, 16'h0000);
    rd(`ADCIRQ_IDX_RESULT2, 16'h0000);
    wr(`ADCIRQ_IDX_MODE, 16'h0001);
    cap(12'hFFF, 12'h5A5);
    rd(`ADCIRQ_IDX_RESULT1, 16'h0FFF);
    rd(`ADCIRQ_IDX_RESULT2, 16'h05A5);
    wr(`ADCIRQ_IDX_RESULT1, 16'h1234);
    rd(`ADCIRQ_IDX_RESULT1, 16'h0FFF);
  endtask
  task automatic t_rerun();
    `CHK("ctrl", {3'b110, 8'h00}, ctl)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ADCIRQ_IDX_MODE, `ADCIRQ_RST_REG);
    rd(`ADCIRQ_IDX_RESULT1, `ADCIRQ_RST_REG);
    `CHK("ctrl", 11'h000, ctl)
  endtask
  initial begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b000;
    {s_axi_arvalid, s_axi_rready, ev, stb} <= 8'h00;
    {s_axi_awaddr, s_axi_araddr, val1, val2} <= 48'h0000_0000_0000;
    s_axi_wdata <= 32'h0000_0000;
    // all four byte lanes on unless a scenario narrows them
    s_axi_wstrb <= 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_events();
    t_mode();
    t_results();
    t_rerun();
    wrap_up();
  end
endmodule
